// >>> src/dcc_regs.vh
// Register map, field positions and encodings of the capture/compare block
`ifndef DCC_REGS_VH
`define DCC_REGS_VH

// Global registers (byte addresses)
`define DCC_CTRL        12'h000
`define DCC_CH_STAT     12'h004
`define DCC_CH_MASK     12'h008
`define DCC_TM_STAT     12'h00c
`define DCC_TM_MASK     12'h010

// Timer register banks, one word per timer
`define DCC_TCTL        12'h020
`define DCC_TVAL        12'h030
`define DCC_TREL        12'h040
`define DCC_TM_AMASK    12'hff0

// Channel register banks, one word per channel
`define DCC_CCM         12'h080
`define DCC_CCV         12'h100
`define DCC_CH_AMASK    12'hf80

// Control register fields
`define DCC_CTRL_STAG   0

// Timer control fields
`define DCC_TC_RUN      0
`define DCC_TC_PS_LO    1
`define DCC_TC_PS_HI    3
`define DCC_TC_GP       4
`define DCC_TC_EXT      5
`define DCC_TC_W        6
`define DCC_STAG_PS     3'h3

// Channel mode fields
`define DCC_MF_MODE_HI  2
`define DCC_MF_TSEL     3
`define DCC_MF_RISE     4
`define DCC_MF_FALL     5
`define DCC_MF_SINGLE   6
`define DCC_MF_W        7

// Channel modes
`define DCC_M_OFF       3'h0
`define DCC_M_CAP       3'h1
`define DCC_M_CMP0      3'h2
`define DCC_M_CMP1      3'h3
`define DCC_M_CMP2      3'h4
`define DCC_M_CMP3      3'h5
`define DCC_M_DBL       3'h6

// Reset values
`define DCC_TREL_RST    16'h0000
`define DCC_CCV_RST     16'h0000

// Bus responses
`define DCC_RESP_OKAY   2'h0
`define DCC_RESP_SLVERR 2'h2

`endif

// >>> src/dcc_timer.v
// One reloadable 16-bit time base with prescaler and count source select
`timescale 1ns/1ns
`include "dcc_regs.vh"
module dcc_timer #(
  parameter W = 16
) (
  // Clock and reset
  input  wire                  aclk,
  input  wire                  aresetn,
  // Configuration
  input  wire [`DCC_TC_W-1:0]  ctl,
  input  wire                  stagger,
  // Count sources
  input  wire                  gp_tick,
  input  wire                  ext_tick,
  // Software access
  input  wire                  wr_cnt,
  input  wire                  wr_rel,
  input  wire [W-1:0]          wdata,
  // State
  output reg  [W-1:0]          cnt_q,
  output reg  [W-1:0]          rel_q,
  output reg                   upd_q,
  output reg                   ovf_q
);

  reg  [7:0] ps_q;
  wire [2:0] psel = ctl[`DCC_TC_PS_HI:`DCC_TC_PS_LO];
  // Staggered operation cannot tick the prescaler faster than every eighth cycle
  wire [2:0] ps_exp = (stagger && psel < `DCC_STAG_PS) ? `DCC_STAG_PS : psel;
  wire [7:0] ps_lim = (8'h01 << ps_exp) - 8'h01;
  wire       ps_end = (ps_q == ps_lim);
  wire       run    = ctl[`DCC_TC_RUN];
  wire       tick   = run & (ctl[`DCC_TC_EXT] ? ext_tick :
                             ctl[`DCC_TC_GP]  ? gp_tick  : ps_end);

  always @(posedge aclk) begin
    if (!aresetn) begin
      ps_q  <= 8'h00;
      cnt_q <= {W{1'b0}};
      rel_q <= `DCC_TREL_RST;
      upd_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      ps_q  <= (!run || ps_end) ? 8'h00 : ps_q + 8'h01;
      upd_q <= 1'b0;
      ovf_q <= 1'b0;
      if (wr_rel)
        rel_q <= wdata;
      if (wr_cnt) begin
        cnt_q <= wdata;
      end else if (tick) begin
        upd_q <= 1'b1;
        if (cnt_q == {W{1'b1}}) begin
          cnt_q <= rel_q;
          ovf_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// >>> src/dcc_top.v
// Dual-array capture/compare unit with AXI4-Lite register access
//
// Notes on behaviour
// - Controls 32 channels at one-cycle resolution, eight cycles when staggered.
// - Four reloadable 16-bit timers, two time bases per array.
// - Timer counts prescaled clock or the general purpose overflow pulses.
// - First timer of each array may count an external input.
// - Sixteen registers per array, each picks timer and compare; only the twelve with pins can also capture.
// - Twelve registers of the second array own one pin each.
// - Mode zero: interrupt on every match, pin untouched.
// - Mode one: pin toggles on every match.
// - Mode two: interrupt only, once per timer period.
// - Mode three: pin high on match, low on overflow, once per period.
// - Double mode: two registers toggle one shared pin on any match.
// - Single-event option stops a register after its first compare event.
// - Capture loads assigned timer into register and raises its interrupt.
// - Capture edge is rising, falling or both.
// - Compare registers checked on each timer update, acting on equality.
`timescale 1ns/1ns
`include "dcc_regs.vh"
module dcc_top #(
  parameter AW    = 12,
  parameter TW    = 16,
  parameter NPIN  = 12
) (
  // Clock and reset
  input  wire            aclk,
  input  wire            aresetn,
  // AXI4-Lite write address
  input  wire [AW-1:0]   s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output reg             s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output reg             s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  // AXI4-Lite read address
  input  wire [AW-1:0]   s_axi_araddr,
  input  wire            s_axi_arvalid,
  output reg             s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  // Count inputs
  input  wire            gp_module_overflow_timer,
  input  wire            ext_cnt_a,
  input  wire            ext_cnt_b,
  // Channel pins of the second array
  input  wire [NPIN-1:0] cc_pin_in,
  output reg  [NPIN-1:0] cc_pin_out,
  output reg  [NPIN-1:0] cc_pin_oe,
  // Interrupt
  output reg             irq
);

  localparam NCH = 32;
  localparam NT  = 4;
  localparam MW  = `DCC_MF_W;

  // Bus state
  reg  [AW-1:0] awaddr_q;
  reg           aw_have_q;
  reg  [31:0]   wdata_q;
  reg  [3:0]    wstrb_q;
  reg           w_have_q;

  // Register state
  reg           stag_q;
  reg  [NCH-1:0] ch_stat_q;
  reg  [NCH-1:0] ch_mask_q;
  reg  [NT-1:0]  tm_stat_q;
  reg  [NT-1:0]  tm_mask_q;
  reg  [`DCC_TC_W-1:0] tctl_q [0:NT-1];
  reg  [MW-1:0]  ccm_q [0:NCH-1];
  reg  [TW-1:0]  ccv_q [0:NCH-1];
  reg  [NCH-1:0] done_q;
  reg  [NCH-1:0] fired_q;
  reg  [NPIN-1:0] pin_prev_q;
  reg            ext_a_prev_q;
  reg            ext_b_prev_q;

  // Timer outputs
  wire [NT*TW-1:0] t_cnt;
  wire [NT*TW-1:0] t_rel;
  wire [NT-1:0]    t_upd;
  wire [NT-1:0]    t_ovf;

  // Per-channel results
  wire [NCH-1:0]    hit;
  wire [NCH-1:0]    cap;
  wire [NCH-1:0]    ch_ovf;
  wire [NCH*TW-1:0] ch_cnt;
  wire [NPIN-1:0]   pin_d;
  wire [NPIN-1:0]   oe_d;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    reg   [31:0] m;
    begin
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // Write decode
  wire           do_wr   = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [AW-1:0]  wa      = awaddr_q;
  wire [4:0]     w_idx   = wa[6:2];
  wire [1:0]     w_tidx  = wa[3:2];
  wire [31:0]    wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                            {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0]    w1c     = wdata_q & wmask;
  wire           wr_ccm  = do_wr && ((wa & `DCC_CH_AMASK) == `DCC_CCM);
  wire           wr_ccv  = do_wr && ((wa & `DCC_CH_AMASK) == `DCC_CCV);
  wire           wr_tctl = do_wr && ((wa & `DCC_TM_AMASK) == `DCC_TCTL);
  wire           wr_tval = do_wr && ((wa & `DCC_TM_AMASK) == `DCC_TVAL);
  wire           wr_trel = do_wr && ((wa & `DCC_TM_AMASK) == `DCC_TREL);
  wire           wr_fix  = do_wr && (wa == `DCC_CTRL || wa == `DCC_CH_STAT ||
                           wa == `DCC_CH_MASK || wa == `DCC_TM_STAT ||
                           wa == `DCC_TM_MASK);
  wire           wr_ok   = wr_ccm | wr_ccv | wr_tctl | wr_tval | wr_trel | wr_fix;
  wire [NCH-1:0] ch_clr  = (do_wr && wa == `DCC_CH_STAT) ? w1c : {NCH{1'b0}};
  wire [NT-1:0]  tm_clr  = (do_wr && wa == `DCC_TM_STAT) ? w1c[NT-1:0] : {NT{1'b0}};

  wire ext_a_tick = ext_cnt_a & ~ext_a_prev_q;
  wire ext_b_tick = ext_cnt_b & ~ext_b_prev_q;

  genvar g;
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_tmr
      wire [31:0] cur = {{(32-TW){1'b0}}, t_cnt[g*TW +: TW]};
      wire [31:0] rel = {{(32-TW){1'b0}}, t_rel[g*TW +: TW]};
      wire [31:0] mc  = merge(cur, wdata_q, wstrb_q);
      wire [31:0] mr  = merge(rel, wdata_q, wstrb_q);
      // Only the primary timer of each array sees an external count
      wire ext_ok = (g == 0) ? ext_a_tick : (g == 2) ? ext_b_tick : 1'b0;
      dcc_timer #(.W(TW)) u_tmr (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ctl      (tctl_q[g]),
        .stagger  (stag_q),
        .gp_tick  (gp_module_overflow_timer),
        .ext_tick (ext_ok),
        .wr_cnt   (wr_tval && w_tidx == g),
        .wr_rel   (wr_trel && w_tidx == g),
        .wdata    (wr_tval ? mc[TW-1:0] : mr[TW-1:0]),
        .cnt_q    (t_cnt[g*TW +: TW]),
        .rel_q    (t_rel[g*TW +: TW]),
        .upd_q    (t_upd[g]),
        .ovf_q    (t_ovf[g])
      );
    end

    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire [MW-1:0] m    = ccm_q[g];
      wire [2:0]    md   = m[`DCC_MF_MODE_HI:0];
      wire [1:0]    ti   = {(g >= 16) ? 1'b1 : 1'b0, m[`DCC_MF_TSEL]};
      wire [TW-1:0] cnt  = t_cnt[ti*TW +: TW];
      wire          cmp  = (md >= `DCC_M_CMP0) && (md <= `DCC_M_DBL);
      wire          once = (md == `DCC_M_CMP2) || (md == `DCC_M_CMP3);
      assign ch_cnt[g*TW +: TW] = cnt;
      assign ch_ovf[g] = t_ovf[ti];
      assign hit[g] = cmp & t_upd[ti] & (cnt == ccv_q[g]) & ~done_q[g] &
                      ~(once & fired_q[g]);
      if (g >= 16 && g < 16 + NPIN) begin : g_cap
        wire rise = cc_pin_in[g-16] & ~pin_prev_q[g-16];
        wire fall = ~cc_pin_in[g-16] & pin_prev_q[g-16];
        assign cap[g] = (md == `DCC_M_CAP) &
                        ((m[`DCC_MF_RISE] & rise) | (m[`DCC_MF_FALL] & fall));
      end else begin : g_nocap
        assign cap[g] = 1'b0;
      end
    end

    for (g = 0; g < NPIN; g = g + 1) begin : g_pin
      wire [2:0] md  = ccm_q[16+g][`DCC_MF_MODE_HI:0];
      // Register eight places up shares this pin in double mode
      wire       dbl = (g < 8) ? (ccm_q[(16+g+8)%NCH][`DCC_MF_MODE_HI:0] == `DCC_M_DBL)
                               : 1'b0;
      wire       dhi = (g < 8) ? (dbl & hit[(16+g+8)%NCH]) : 1'b0;
      wire       tog = (hit[16+g] & (md == `DCC_M_CMP1 || md == `DCC_M_DBL)) | dhi;
      assign pin_d[g] = (md == `DCC_M_CMP3) ?
                        (hit[16+g] ? 1'b1 : ch_ovf[16+g] ? 1'b0 : cc_pin_out[g]) :
                        (tog ? ~cc_pin_out[g] : cc_pin_out[g]);
      assign oe_d[g] = (md == `DCC_M_CMP1) || (md == `DCC_M_CMP3) ||
                       (md == `DCC_M_DBL) || dbl;
    end
  endgenerate

  // Read decode
  reg  [31:0] rd_d;
  reg         rd_err;
  wire [AW-1:0] ra     = s_axi_araddr;
  wire [4:0]    r_idx  = ra[6:2];
  wire [1:0]    r_tidx = ra[3:2];

  always @* begin
    rd_d   = 32'h0000_0000;
    rd_err = 1'b0;
    if (ra == `DCC_CTRL)
      rd_d[`DCC_CTRL_STAG] = stag_q;
    else if (ra == `DCC_CH_STAT)
      rd_d = ch_stat_q;
    else if (ra == `DCC_CH_MASK)
      rd_d = ch_mask_q;
    else if (ra == `DCC_TM_STAT)
      rd_d[NT-1:0] = tm_stat_q;
    else if (ra == `DCC_TM_MASK)
      rd_d[NT-1:0] = tm_mask_q;
    else if ((ra & `DCC_TM_AMASK) == `DCC_TCTL)
      rd_d[`DCC_TC_W-1:0] = tctl_q[r_tidx];
    else if ((ra & `DCC_TM_AMASK) == `DCC_TVAL)
      rd_d[TW-1:0] = t_cnt[r_tidx*TW +: TW];
    else if ((ra & `DCC_TM_AMASK) == `DCC_TREL)
      rd_d[TW-1:0] = t_rel[r_tidx*TW +: TW];
    else if ((ra & `DCC_CH_AMASK) == `DCC_CCM)
      rd_d[MW-1:0] = ccm_q[r_idx];
    else if ((ra & `DCC_CH_AMASK) == `DCC_CCV)
      rd_d[TW-1:0] = ccv_q[r_idx];
    else
      rd_err = 1'b1;
  end

  // AXI4-Lite handshakes
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DCC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DCC_RESP_OKAY;
      awaddr_q      <= {AW{1'b0}};
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
      end
      // Address and data stay closed until the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_d;
        s_axi_rresp   <= rd_err ? `DCC_RESP_SLVERR : `DCC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Configuration, status and interrupt
  wire [NCH-1:0] ch_stat_d = (ch_stat_q & ~ch_clr) | hit | cap;
  wire [NT-1:0]  tm_stat_d = (tm_stat_q & ~tm_clr) | t_ovf;
  integer i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      stag_q       <= 1'b0;
      ch_stat_q    <= {NCH{1'b0}};
      ch_mask_q    <= {NCH{1'b0}};
      tm_stat_q    <= {NT{1'b0}};
      tm_mask_q    <= {NT{1'b0}};
      irq          <= 1'b0;
      ext_a_prev_q <= 1'b0;
      ext_b_prev_q <= 1'b0;
      pin_prev_q   <= {NPIN{1'b0}};
      cc_pin_out   <= {NPIN{1'b0}};
      cc_pin_oe    <= {NPIN{1'b0}};
      done_q       <= {NCH{1'b0}};
      fired_q      <= {NCH{1'b0}};
      for (i = 0; i < NT; i = i + 1)
        tctl_q[i] <= {`DCC_TC_W{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        ccm_q[i] <= {MW{1'b0}};
        ccv_q[i] <= `DCC_CCV_RST;
      end
    end else begin
      // Set wins over a clear in the same cycle
      ch_stat_q    <= ch_stat_d;
      tm_stat_q    <= tm_stat_d;
      irq          <= |(ch_stat_q & ch_mask_q) | |(tm_stat_q & tm_mask_q);
      ext_a_prev_q <= ext_cnt_a;
      ext_b_prev_q <= ext_cnt_b;
      pin_prev_q   <= cc_pin_in;
      cc_pin_out   <= pin_d;
      cc_pin_oe    <= oe_d;
      if (do_wr && wa == `DCC_CTRL)
        stag_q <= (stag_q & ~wmask[`DCC_CTRL_STAG]) | w1c[`DCC_CTRL_STAG];
      if (do_wr && wa == `DCC_CH_MASK)
        ch_mask_q <= merge(ch_mask_q, wdata_q, wstrb_q);
      if (do_wr && wa == `DCC_TM_MASK)
        tm_mask_q <= (tm_mask_q & ~wmask[NT-1:0]) | w1c[NT-1:0];
      if (wr_tctl)
        tctl_q[w_tidx] <= (tctl_q[w_tidx] & ~wmask[`DCC_TC_W-1:0]) | w1c[`DCC_TC_W-1:0];
      for (i = 0; i < NCH; i = i + 1) begin
        if (wr_ccv && w_idx == i)
          ccv_q[i] <= (ccv_q[i] & ~wmask[TW-1:0]) | w1c[TW-1:0];
        else if (cap[i])
          ccv_q[i] <= ch_cnt[i*TW +: TW];
        if (wr_ccm && w_idx == i) begin
          ccm_q[i]   <= (ccm_q[i] & ~wmask[MW-1:0]) | w1c[MW-1:0];
          done_q[i]  <= 1'b0;
          fired_q[i] <= 1'b0;
        end else begin
          done_q[i]  <= done_q[i] | (hit[i] & ccm_q[i][`DCC_MF_SINGLE]);
          fired_q[i] <= hit[i] | (fired_q[i] & ~ch_ovf[i]);
        end
      end
    end
  end

endmodule

// >>> verif/dcc_pin_model.sv
// Outside signal source on the channel pins of the second array
`timescale 1ns/1ns
module dcc_pin_model (
  // Device side
  input  wire logic [11:0] pin_out,
  input  wire logic [11:0] pin_oe,
  // Outside source level
  input  wire logic [11:0] drv_lvl,
  // Resolved wire
  output wire logic [11:0] pin_in
);
  // Device wins where it drives, outside source elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_lvl);
endmodule

// >>> verif/dcc_top_asserts.sv
// Port-level checks of the capture/compare block
`timescale 1ns/1ns
module dcc_top_asserts #(
  parameter AW   = 12,
  parameter NPIN = 12
) (
  // Clock and reset
  input wire logic            aclk,
  input wire logic            aresetn,
  // Register bus
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  // Pins and interrupt
  input wire logic [NPIN-1:0] cc_pin_out,
  input wire logic [NPIN-1:0] cc_pin_oe,
  input wire logic            irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1]
    (s_axi_awready && s_axi_wready)) else $error("write channel not freed");
  pin_owned_a: assert property (!(|((cc_pin_out ^ $past(cc_pin_out)) & ~cc_pin_oe &
    ~$past(cc_pin_oe)))) else $error("undriven pin changed");
  rst_vals_a: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid &&
    cc_pin_oe == 0 && cc_pin_out == 0 && s_axi_awready && s_axi_arready)
    else $error("bad value after reset");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq));
  cover property (|(cc_pin_oe & (cc_pin_out ^ $past(cc_pin_out))));
endmodule
bind dcc_top dcc_top_asserts #(.AW(AW), .NPIN(NPIN)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cc_pin_out(cc_pin_out),
  .cc_pin_oe(cc_pin_oe), .irq(irq)
);

// >>> verif/dcc_top_tb.sv
// Self-checking testbench of the capture/compare block
`timescale 1ns/1ns
`include "dcc_regs.vh"
module dcc_top_tb;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } dcc_row_t;
  typedef struct packed {
    logic [7:0]  m;
    logic [15:0] t;
    logic        l;
    logic [15:0] e;
  } dcc_cap_t;
  logic        aclk, aresetn, awv, wv, br, arv, rr, gp, exa, exb, v;
  logic [11:0] aw, ar, drv;
  logic [31:0] wd;
  wire         awr, wrdy, bv, arr, rv, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdat;
  wire  [11:0] pin_in, pin_o, pin_e;
  int          mismatches, comparisons, i, n;
  dcc_row_t    rows [0:7];
  dcc_cap_t    caps [0:5];

  dcc_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .gp_module_overflow_timer(gp), .ext_cnt_a(exa), .ext_cnt_b(exb),
    .cc_pin_in(pin_in), .cc_pin_out(pin_o), .cc_pin_oe(pin_e), .irq(irq)
  );
  dcc_pin_model pins_u (.pin_out(pin_o), .pin_oe(pin_e), .drv_lvl(drv), .pin_in(pin_in));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask

  task limit(input int c, input int lim);
    if (c >= lim) begin
      mismatches++;
      $display("FAIL %0t wait ran out", $time);
      finish_test;
    end
  endtask

  // Address and data offered together, each released once taken
  task bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int c;
    @(posedge aclk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    c = 0;
    do begin
      @(posedge aclk);
      c++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && c < 100);
    br <= 1'b0;
    limit(c, 100);
    chk({30'h0, bresp}, {30'h0, r});
  endtask

  task bus_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    int c;
    @(posedge aclk);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    c = 0;
    do begin
      @(posedge aclk);
      c++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && c < 100);
    rr <= 1'b0;
    limit(c, 100);
    chk(rdat, e);
    chk({30'h0, rresp}, {30'h0, r});
  endtask

  task cfg(input logic [11:0] off, input logic [31:0] m, input logic [31:0] val);
    bus_wr(`DCC_CCM + off, m, `DCC_RESP_OKAY);
    bus_wr(`DCC_CCV + off, val, `DCC_RESP_OKAY);
  endtask

  task chg(input int b, output int c);
    v = pin_o[b];
    c = 0;
    while (pin_o[b] === v && c < 300) begin
      @(posedge aclk);
      c++;
    end
    limit(c, 300);
  endtask

  // First change may end a partial period, so the second is measured
  task gap(input int b, input int e);
    int c;
    chg(b, c);
    chg(b, c);
    chk(c, e);
  endtask

  initial begin
    {aresetn, awv, wv, br, arv, rr, gp, exa, exb} = 9'h0;
    {aw, ar, drv, wd} = 68'h0;
    mismatches = 0;
    comparisons = 0;
    rows = '{'{`DCC_TREL, 32'h1234, 32'h1234, 2'h0},
      '{`DCC_TREL + 12'hc, 32'hffffabcd, 32'habcd, 2'h0},
      '{`DCC_CH_MASK, 32'hffffffff, 32'hffffffff, 2'h0},
      '{`DCC_TM_MASK, 32'hff, 32'hf, 2'h0}, '{`DCC_CCM + 12'h14, 32'h78, 32'h78, 2'h0},
      '{`DCC_CCV + 12'h7c, 32'h5a5a, 32'h5a5a, 2'h0},
      '{`DCC_CTRL, 32'hfffffffe, 32'h0, 2'h0}, '{12'h200, 32'h1, 32'h0, `DCC_RESP_SLVERR}};
    caps = '{'{8'h11, 16'h1234, 1'b1, 16'h1234}, '{8'h11, 16'h2222, 1'b0, 16'h1234},
      '{8'h21, 16'h3333, 1'b1, 16'h1234}, '{8'h21, 16'h4444, 1'b0, 16'h4444},
      '{8'h31, 16'h5555, 1'b1, 16'h5555}, '{8'h31, 16'h6666, 1'b0, 16'h6666}};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      bus_rd(rows[i].a, 32'h0, rows[i].r);
      bus_wr(rows[i].a, rows[i].d, rows[i].r);
      bus_rd(rows[i].a, rows[i].e, rows[i].r);
    end
    // Compare modes on the primary timer of array B, period of 16 counts
    bus_wr(`DCC_TREL + 12'h8, 32'hfff0, `DCC_RESP_OKAY);
    bus_wr(`DCC_TVAL + 12'h8, 32'hfff0, `DCC_RESP_OKAY);
    cfg(12'h40, 32'h3, 32'hfff4);
    cfg(12'h44, 32'h5, 32'hfff8);
    cfg(12'h48, 32'h6, 32'hfff2);
    cfg(12'h68, 32'h6, 32'hfffa);
    cfg(12'h4c, 32'h45, 32'hfff4);
    bus_wr(`DCC_TCTL + 12'h8, 32'h1, `DCC_RESP_OKAY);
    n = 0;
    v = pin_o[3];
    repeat (80) begin
      @(posedge aclk);
      if (pin_o[3] !== v) n++;
      v = pin_o[3];
    end
    chk(n, 2);
    gap(0, 16);
    gap(1, 8);
    gap(2, 8);
    chk({20'h0, pin_e & 12'h0ff}, 32'hf);
    chk({31'h0, irq}, 32'h1);
    // Timer overflows stay pending, so their mask must drop as well
    bus_wr(`DCC_CH_MASK, 32'h0, `DCC_RESP_OKAY);
    bus_wr(`DCC_TM_MASK, 32'h0, `DCC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    bus_wr(`DCC_TCTL + 12'h8, 32'h0, `DCC_RESP_OKAY);
    bus_wr(`DCC_CH_STAT, 32'hffffffff, `DCC_RESP_OKAY);
    bus_rd(`DCC_CH_STAT, 32'h0, `DCC_RESP_OKAY);
    // Interrupt-only modes raise the request and leave the pin alone
    bus_wr(`DCC_CH_MASK, 32'h00100000, `DCC_RESP_OKAY);
    for (i = 0; i < 2; i++) begin
      cfg(12'h50, (i == 0) ? 32'h2 : 32'h4, 32'hfff4);
      bus_wr(`DCC_CH_STAT, 32'h00100000, `DCC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      bus_wr(`DCC_TCTL + 12'h8, 32'h1, `DCC_RESP_OKAY);
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
        @(posedge aclk);
        n++;
      end
      limit(n, 40);
      chk({20'h0, pin_e & 12'h010}, 32'h0);
      bus_wr(`DCC_TCTL + 12'h8, 32'h0, `DCC_RESP_OKAY);
    end
    // Capture with the timer held still, each edge kind
    bus_wr(`DCC_CH_STAT, 32'hffffffff, `DCC_RESP_OKAY);
    for (i = 0; i < 6; i++) begin
      bus_wr(`DCC_CCM + 12'h54, {24'h0, caps[i].m}, `DCC_RESP_OKAY);
      bus_wr(`DCC_TVAL + 12'h8, {16'h0, caps[i].t}, `DCC_RESP_OKAY);
      drv[5] <= caps[i].l;
      repeat (4) @(posedge aclk);
      bus_rd(`DCC_CCV + 12'h54, {16'h0, caps[i].e}, `DCC_RESP_OKAY);
    end
    bus_rd(`DCC_CH_STAT, 32'h00200000, `DCC_RESP_OKAY);
    // Outside count sources, five pulses each
    for (i = 0; i < 3; i++) begin
      bus_wr(`DCC_TVAL + 12'(4 * i), 32'h0, `DCC_RESP_OKAY);
      bus_wr(`DCC_TCTL + 12'(4 * i), (i == 1) ? 32'h11 : 32'h21, `DCC_RESP_OKAY);
    end
    repeat (10) begin
      @(posedge aclk);
      exa <= ~exa;
      exb <= ~exb;
      gp <= ~gp;
    end
    for (i = 0; i < 3; i++) bus_rd(`DCC_TVAL + 12'(4 * i), 32'h5, `DCC_RESP_OKAY);
    // Prescaled and staggered rates on the secondary timer of array B
    bus_wr(`DCC_TREL + 12'hc, 32'hfff0, `DCC_RESP_OKAY);
    bus_wr(`DCC_TVAL + 12'hc, 32'hfff0, `DCC_RESP_OKAY);
    cfg(12'h58, 32'hb, 32'hfff0);
    bus_wr(`DCC_TCTL + 12'hc, 32'h3, `DCC_RESP_OKAY);
    gap(6, 32);
    bus_wr(`DCC_CTRL, 32'h1, `DCC_RESP_OKAY);
    bus_wr(`DCC_TCTL + 12'hc, 32'h1, `DCC_RESP_OKAY);
    gap(6, 128);
    // Mid-run reset puts pins, interrupt and registers back to rest
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({19'h0, irq, pin_o}, 32'h0);
    bus_rd(`DCC_CTRL, 32'h0, `DCC_RESP_OKAY);
    bus_rd(`DCC_TCTL + 12'hc, 32'h0, `DCC_RESP_OKAY);
    finish_test;
  end
endmodule
